// *** jmb_jog_bank.sv ***
// Jog control and motor parameter bank selection driven by intelligent input terminals.
// Assumes terminal and run pins are asynchronous, and configuration and motor status are on clk.
`timescale 1ns/100ps
module jmb_jog_bank #(
  parameter int NUM_TERM = 8,
  parameter int FREQ_W = jmb_pkg::FREQ_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Terminal pins.
  input wire logic [NUM_TERM-1:0] termPin,
  input wire logic forwardRunPin,
  input wire logic reverseRunPin,
  // Configuration.
  input wire logic [NUM_TERM-1:0][7:0] terminalFunctionAssign,
  input wire logic [2:0] jogStopMethod,
  input wire logic [FREQ_W-1:0] jogFrequency,
  input wire logic [FREQ_W-1:0] startFrequency,
  // Drive core status.
  input wire logic motorRunning,
  // Motor parameter banks.
  input wire jmb_pkg::jmb_motor_set_t bank1Set,
  input wire jmb_pkg::jmb_motor_set_t bank2Set,
  input wire jmb_pkg::jmb_motor_set_t bank3Set,
  // Jog command and selected settings.
  output jmb_pkg::jmb_jog_cmd_t jogCmd,
  output jmb_pkg::jmb_motor_set_t activeSet
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  if (NUM_TERM < 2) begin : gNumTermCheck
    $error("At least two terminals are needed for the two bank selects.");
  end
  if (FREQ_W != jmb_pkg::FREQ_W) begin : gFreqCheck
    $error("Frequency width must match the jog frequency limit constant.");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  logic [NUM_TERM-1:0] termSync;
  logic forwardRun;
  logic reverseRun;

  // Run pins share the terminals' synchroniser so the order of jog and run is kept.
  jmb_sync #(
    .WIDTH(NUM_TERM + 2)
  ) uPinSync (
    .clk(clk),
    .resetn(resetn),
    .pinIn({forwardRunPin, reverseRunPin, termPin}),
    .syncOut({forwardRun, reverseRun, termSync})
  );

  //////////////////////////////////////////////////////////////////////////////
  // Terminal function decode.

  logic [NUM_TERM-1:0] jogHit;
  logic [NUM_TERM-1:0] bank2Hit;
  logic [NUM_TERM-1:0] bank3Hit;

  // Several terminals may carry one code; any of them active asserts the function.
  for (genvar t = 0; t < NUM_TERM; t++) begin : gTermDecode
    assign jogHit[t] = termSync[t] && (terminalFunctionAssign[t] == jmb_pkg::FUNC_JOG);
    assign bank2Hit[t] = termSync[t] && (terminalFunctionAssign[t] == jmb_pkg::FUNC_BANK2);
    assign bank3Hit[t] = termSync[t] && (terminalFunctionAssign[t] == jmb_pkg::FUNC_BANK3);
  end

  wire jogRequest = |jogHit;
  wire bank2Select = |bank2Hit;
  wire bank3Select = |bank3Hit;
  wire anyRun = forwardRun || reverseRun;

  //////////////////////////////////////////////////////////////////////////////
  // Stop method decode.

  // One decode wire per stop method code.
  wire isFreeLock = (jogStopMethod == jmb_pkg::JSM_FREE_LOCK);
  wire isDecelLock = (jogStopMethod == jmb_pkg::JSM_DECEL_LOCK);
  wire isDcbLock = (jogStopMethod == jmb_pkg::JSM_DCB_LOCK);
  wire isFreeOpen = (jogStopMethod == jmb_pkg::JSM_FREE_OPEN);
  wire isDecelOpen = (jogStopMethod == jmb_pkg::JSM_DECEL_OPEN);
  wire isDcbOpen = (jogStopMethod == jmb_pkg::JSM_DCB_OPEN);

  wire lockWhileRunning = isFreeLock || isDecelLock || isDcbLock;
  wire openWhileRunning = isFreeOpen || isDecelOpen || isDcbOpen;
  wire decelByMethod = isDecelLock || isDecelOpen;
  wire dcbByMethod = isDcbLock || isDcbOpen;

  jmb_pkg::jmb_stop_t methodStop;

  // Codes above five are treated as free-run, the safest way to release the motor.
  assign methodStop =
    decelByMethod ? jmb_pkg::JMB_STOP_DECEL :
    dcbByMethod ? jmb_pkg::JMB_STOP_DCB :
    jmb_pkg::JMB_STOP_FREE;

  //////////////////////////////////////////////////////////////////////////////
  // Order of jog request and forward run.

  // Set while forward has been active since a moment the jog request was absent.
  logic forwardFirst_ff;
  logic nxt_forwardFirst;

  // A jog request arriving in the same cycle as forward counts as jog first.
  assign nxt_forwardFirst = forwardRun && (forwardFirst_ff || !jogRequest);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      forwardFirst_ff <= 1'b0;
    end else begin
      forwardFirst_ff <= nxt_forwardFirst;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Jog frequency limiting.

  logic [FREQ_W-1:0] jogFreqRaised;
  logic [FREQ_W-1:0] jogFreqLimited;

  // A non-zero setting below the start frequency is raised to it.
  assign jogFreqRaised = (jogFrequency < startFrequency) ? startFrequency : jogFrequency;

  // The cut to 9.99 Hz comes last, so a start frequency above it cannot lift the jog output.
  assign jogFreqLimited =
    (jogFrequency == jmb_pkg::JOG_FREQ_ZERO) ? jmb_pkg::JOG_FREQ_ZERO :
    (jogFreqRaised > jmb_pkg::JOG_FREQ_MAX) ? jmb_pkg::JOG_FREQ_MAX :
    jogFreqRaised;

  //////////////////////////////////////////////////////////////////////////////
  // Jog sequencer.

  // Idle, run and stop is the usual path; hold parks a refused request.
  typedef enum logic [1:0] {
    JOG_IDLE = 2'b00,
    JOG_RUN = 2'b01,
    JOG_STOP = 2'b11,
    JOG_HOLD = 2'b10
  } jmb_jog_state_t;

  jmb_jog_state_t state_ff;
  jmb_jog_state_t nxt_state;

  wire jogStartAsk = jogRequest && anyRun;
  wire jogBlocked = lockWhileRunning && (motorRunning || forwardFirst_ff);
  wire jogAllowed = openWhileRunning || !jogBlocked;
  // Releasing the jog request or both run commands ends the jog.
  wire jogEnd = !jogRequest || !anyRun;
  // In the open codes, a jog let go under a held forward command coasts the motor.
  wire freeByForward = openWhileRunning && !jogRequest && forwardRun;

  jmb_pkg::jmb_stop_t endStop;

  assign endStop = freeByForward ? jmb_pkg::JMB_STOP_FREE : methodStop;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      JOG_IDLE: begin
        if (jogStartAsk && jogAllowed) begin
          nxt_state = JOG_RUN;
        end else if (jogStartAsk) begin
          nxt_state = JOG_HOLD;
        end
      end
      JOG_RUN: begin
        if (jogEnd) begin
          nxt_state = JOG_STOP;
        end
      end
      JOG_STOP: begin
        // One cycle here makes the stop request a single pulse.
        nxt_state = JOG_IDLE;
      end
      JOG_HOLD: begin
        // A refused request waits until jog or run is released before another try.
        if (jogEnd) begin
          nxt_state = JOG_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= JOG_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Jog command outputs.

  jmb_pkg::jmb_jog_cmd_t jogCmd_ff;
  jmb_pkg::jmb_jog_cmd_t nxt_jogCmd;

  // Transition strobes taken from the present and the next state.
  wire enterRun = (state_ff == JOG_IDLE) && (nxt_state == JOG_RUN);
  wire enterHold = (state_ff == JOG_IDLE) && (nxt_state == JOG_HOLD);
  wire enterStop = (state_ff == JOG_RUN) && (nxt_state == JOG_STOP);

  // The stop kind outlives its pulse until the next jog starts, so the core may read it late.
  always_comb begin
    nxt_jogCmd = jogCmd_ff;
    nxt_jogCmd.stopReq = enterStop;
    nxt_jogCmd.refused = enterHold;
    if (enterRun) begin
      nxt_jogCmd.active = 1'b1;
      nxt_jogCmd.freq = jogFreqLimited;
      nxt_jogCmd.stopKind = jmb_pkg::JMB_STOP_NONE;
    end else if (enterStop) begin
      nxt_jogCmd.active = 1'b0;
      nxt_jogCmd.freq = jmb_pkg::JOG_FREQ_ZERO;
      nxt_jogCmd.stopKind = endStop;
    end else if (state_ff == JOG_RUN) begin
      // The jog frequency may be retuned while jogging.
      nxt_jogCmd.freq = jogFreqLimited;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      jogCmd_ff <= jmb_pkg::JOG_CMD_RESET;
    end else begin
      jogCmd_ff <= nxt_jogCmd;
    end
  end

  assign jogCmd = jogCmd_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Motor bank selection.

  jmb_pkg::jmb_bank_t requestedBank;
  jmb_pkg::jmb_bank_t bank_ff;
  jmb_pkg::jmb_bank_t nxt_bank;

  // The second-bank select masks the third.
  assign requestedBank =
    bank2Select ? jmb_pkg::JMB_BANK2 :
    bank3Select ? jmb_pkg::JMB_BANK3 :
    jmb_pkg::JMB_BANK1;

  // The motor counts as stopped only when neither the core nor the jog run it.
  wire motorStopped = !motorRunning && (state_ff != JOG_RUN);

  // A selection made while running stays on the pins and is taken on the first stopped cycle.
  assign nxt_bank = motorStopped ? requestedBank : bank_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bank_ff <= jmb_pkg::BANK_RESET;
    end else begin
      bank_ff <= nxt_bank;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Settings group multiplexer.

  jmb_pkg::jmb_motor_set_t activeSet_ff;
  jmb_pkg::jmb_motor_set_t nxt_activeSet;

  // The whole group moves together so no mixed set is ever presented.
  assign nxt_activeSet =
    (bank_ff == jmb_pkg::JMB_BANK2) ? bank2Set :
    (bank_ff == jmb_pkg::JMB_BANK3) ? bank3Set :
    bank1Set;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      activeSet_ff <= jmb_pkg::SET_RESET;
    end else begin
      activeSet_ff <= nxt_activeSet;
    end
  end

  // The bank number itself is kept internal; only the settings leave the block.
  assign activeSet = activeSet_ff;

endmodule

// *** jmb_jog_bank_props.sv ***
// Concurrent checks on the jog command and bank select ports.
// Assumes configuration and bank sets change only while no jog runs.
`timescale 1ns/100ps
module jmb_jog_bank_props #(
  parameter int FREQ_W = jmb_pkg::FREQ_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Watched inputs.
  input wire logic [2:0] jogStopMethod,
  input wire logic [FREQ_W-1:0] jogFrequency,
  input wire logic [FREQ_W-1:0] startFrequency,
  input wire logic motorRunning,
  // Watched outputs.
  input wire jmb_pkg::jmb_jog_cmd_t jogCmd,
  input wire jmb_pkg::jmb_motor_set_t activeSet
);
  logic locked;
  jmb_pkg::jmb_stop_t lockKind;
  assign locked = jogStopMethod <= 3'h2;
  assign lockKind = (jogStopMethod == 3'h0) ? jmb_pkg::JMB_STOP_FREE :
    (jogStopMethod == 3'h1) ? jmb_pkg::JMB_STOP_DECEL : jmb_pkg::JMB_STOP_DCB;

  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_freq_max;
    jogCmd.active |-> jogCmd.freq <= jmb_pkg::JOG_FREQ_MAX;
  endproperty
  a_freq_max: assert property (p_freq_max) else $error("jog frequency above limit");
  property p_freq_cfg;
    jogCmd.active && jogFrequency >= startFrequency && jogFrequency <= 10'h3e7 |-> jogCmd.freq == jogFrequency;
  endproperty
  a_freq_cfg: assert property (p_freq_cfg) else $error("jog frequency differs from setting");
  property p_kind_lock;
    jogCmd.stopReq && locked |-> jogCmd.stopKind == lockKind;
  endproperty
  a_kind_lock: assert property (p_kind_lock) else $error("wrong stop kind");
  property p_stop_edge;
    $fell(jogCmd.active) |-> jogCmd.stopReq;
  endproperty
  a_stop_edge: assert property (p_stop_edge) else $error("jog ended without stop request");
  property p_stop_pulse;
    jogCmd.stopReq |=> !jogCmd.stopReq;
  endproperty
  a_stop_pulse: assert property (p_stop_pulse) else $error("stop request longer than one cycle");
  property p_ref_lock;
    jogCmd.refused |-> locked && !jogCmd.active;
  endproperty
  a_ref_lock: assert property (p_ref_lock) else $error("refusal in open mode or while jogging");
  property p_lock_start;
    $rose(jogCmd.active) && locked |-> !$past(motorRunning);
  endproperty
  a_lock_start: assert property (p_lock_start) else $error("jog started while running");
  property p_freeze;
    motorRunning [*3] |=> $stable(activeSet);
  endproperty
  a_freeze: assert property (p_freeze) else $error("bank changed while running");
endmodule

bind jmb_jog_bank jmb_jog_bank_props #(.FREQ_W(FREQ_W)) u_props (.clk(clk), .resetn(resetn),
  .jogStopMethod(jogStopMethod), .jogFrequency(jogFrequency), .startFrequency(startFrequency),
  .motorRunning(motorRunning), .jogCmd(jogCmd), .activeSet(activeSet));

// *** jmb_jog_bank_test.sv ***
// Self-checking bench for jog control and motor bank selection.
// Assumes the terminal model drives all pins and inputs change at the falling edge.
`timescale 1ns/100ps
module jmb_jog_bank_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] jogStopMethod = 3'h0;
  logic [9:0] jogFrequency = 10'h000;
  logic [9:0] startFrequency = 10'h032;
  logic motorRunning = 1'b0;
  logic [7:0][7:0] funcAssign = 64'h0000000000110806;
  jmb_pkg::jmb_motor_set_t b1 = {7{16'h1111}};
  jmb_pkg::jmb_motor_set_t b2 = {7{16'h2222}};
  jmb_pkg::jmb_motor_set_t b3 = {7{16'h3333}};
  logic [7:0] termPin;
  logic forwardRunPin;
  logic reverseRunPin;
  jmb_pkg::jmb_jog_cmd_t jogCmd;
  jmb_pkg::jmb_motor_set_t activeSet;
  jmb_pkg::jmb_stop_t kindSeen;
  logic refSeen;
  logic stopSeen;
  int checked = 0;
  int bad_count = 0;

  always #50 clk = ~clk;

  jmb_term_model model (.clk(clk), .termPin(termPin), .forwardRunPin(forwardRunPin),
    .reverseRunPin(reverseRunPin));
  jmb_jog_bank uut (.clk(clk), .resetn(resetn), .termPin(termPin), .forwardRunPin(forwardRunPin),
    .reverseRunPin(reverseRunPin), .terminalFunctionAssign(funcAssign), .jogStopMethod(jogStopMethod),
    .jogFrequency(jogFrequency), .startFrequency(startFrequency), .motorRunning(motorRunning),
    .bank1Set(b1), .bank2Set(b2), .bank3Set(b3), .jogCmd(jogCmd), .activeSet(activeSet));

  // One-cycle pulses are caught mid-cycle and held for the scenario.
  always @(negedge clk) begin
    if (jogCmd.refused === 1'b1) refSeen = 1'b1;
    if (jogCmd.stopReq === 1'b1) begin
      stopSeen = 1'b1;
      kindSeen = jogCmd.stopKind;
    end
  end

  ////////////////////////////////////////
  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic bank(input logic s2, input logic s3, input jmb_pkg::jmb_motor_set_t e);
    model.setBank(s2, s3);
    repeat (6) @(negedge clk);
    check("active set", activeSet, e);
  endtask

  task automatic runJog(input logic [2:0] m, input logic rev, input logic runFirst, input logic run,
      input logic relRun, input logic [9:0] f, input jmb_pkg::jmb_stop_t k);
    logic act;
    logic [9:0] ef;
    act = k != jmb_pkg::JMB_STOP_NONE;
    ef = (f < startFrequency) ? startFrequency : f;
    ef = (f == 10'h000) ? 10'h000 : (ef > 10'h3e7) ? 10'h3e7 : ef;
    @(negedge clk);
    jogStopMethod = m;
    jogFrequency = f;
    motorRunning = run;
    {refSeen, stopSeen} = 2'h0;
    model.startJog(rev, runFirst);
    repeat (6) @(negedge clk);
    check("jog active", jogCmd.active, act);
    check("jog refused", refSeen, !act);
    check("jog freq", jogCmd.freq, act ? ef : 10'h000);
    model.endJog(relRun);
    repeat (6) @(negedge clk);
    check("stop seen", stopSeen, act);
    if (act) check("stop kind", kindSeen, k);
    motorRunning = 1'b0;
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    check("reset set", activeSet, b1);
    bank(1'b1, 1'b0, b2);
    bank(1'b1, 1'b1, b2);
    bank(1'b0, 1'b1, b3);
    bank(1'b0, 1'b0, b1);
    motorRunning = 1'b1;
    bank(1'b0, 1'b1, b1);
    motorRunning = 1'b0;
    repeat (6) @(negedge clk);
    check("set after stop", activeSet, b3);
    runJog(3'h0, 0, 0, 0, 0, 10'h3e7, jmb_pkg::JMB_STOP_FREE);
    runJog(3'h1, 0, 0, 0, 0, 10'h000, jmb_pkg::JMB_STOP_DECEL);
    runJog(3'h2, 0, 0, 0, 0, 10'h005, jmb_pkg::JMB_STOP_DCB);
    runJog(3'h3, 0, 0, 0, 0, 10'h3e8, jmb_pkg::JMB_STOP_FREE);
    runJog(3'h4, 0, 0, 0, 1, 10'h12c, jmb_pkg::JMB_STOP_DECEL);
    runJog(3'h5, 0, 0, 0, 1, 10'h12c, jmb_pkg::JMB_STOP_DCB);
    runJog(3'h0, 0, 1, 0, 0, 10'h12c, jmb_pkg::JMB_STOP_NONE);
    runJog(3'h1, 0, 0, 1, 0, 10'h12c, jmb_pkg::JMB_STOP_NONE);
    runJog(3'h3, 0, 1, 0, 0, 10'h12c, jmb_pkg::JMB_STOP_FREE);
    runJog(3'h4, 0, 0, 1, 1, 10'h12c, jmb_pkg::JMB_STOP_DECEL);
    runJog(3'h1, 1, 0, 0, 0, 10'h12c, jmb_pkg::JMB_STOP_DECEL);
    runJog(3'h4, 0, 0, 0, 0, 10'h12c, jmb_pkg::JMB_STOP_FREE);
    runJog(3'h6, 0, 1, 1, 0, 10'h12c, jmb_pkg::JMB_STOP_FREE);
    startFrequency = 10'h3f0;
    runJog(3'h4, 0, 0, 0, 1, 10'h12c, jmb_pkg::JMB_STOP_DECEL);
    startFrequency = 10'h032;
    finish_test();
  end

  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
endmodule

// *** jmb_pkg.sv ***
// Shared constants and types for the jog and motor bank select block.
// Assumes terminal function codes are held as two-digit decimal values in eight bits.
package jmb_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Terminal function codes.
  localparam logic [7:0] FUNC_JOG = 8'h06;
  localparam logic [7:0] FUNC_BANK2 = 8'h08;
  localparam logic [7:0] FUNC_BANK3 = 8'h11;

  //////////////////////////////////////////////////////////////////////////////
  // Jog stop method codes.
  localparam logic [2:0] JSM_FREE_LOCK = 3'h0;
  localparam logic [2:0] JSM_DECEL_LOCK = 3'h1;
  localparam logic [2:0] JSM_DCB_LOCK = 3'h2;
  localparam logic [2:0] JSM_FREE_OPEN = 3'h3;
  localparam logic [2:0] JSM_DECEL_OPEN = 3'h4;
  localparam logic [2:0] JSM_DCB_OPEN = 3'h5;

  //////////////////////////////////////////////////////////////////////////////
  // Jog frequency in units of 0.01 Hz.
  localparam int FREQ_W = 10;
  localparam logic [FREQ_W-1:0] JOG_FREQ_MAX = 10'h3e7;
  localparam logic [FREQ_W-1:0] JOG_FREQ_ZERO = 10'h000;

  //////////////////////////////////////////////////////////////////////////////
  // Per-motor settings group, switched as one unit.
  localparam int SET_W = 16;

  typedef enum logic [1:0] {
    JMB_STOP_NONE = 2'h0,
    JMB_STOP_FREE = 2'h1,
    JMB_STOP_DECEL = 2'h2,
    JMB_STOP_DCB = 2'h3
  } jmb_stop_t;

  typedef enum logic [1:0] {
    JMB_BANK1 = 2'h0,
    JMB_BANK2 = 2'h1,
    JMB_BANK3 = 2'h2
  } jmb_bank_t;

  typedef struct packed {
    logic [SET_W-1:0] accelTime;
    logic [SET_W-1:0] decelTime;
    logic [SET_W-1:0] baseFreq;
    logic [SET_W-1:0] maxFreq;
    logic [SET_W-1:0] torqueBoost;
    logic [SET_W-1:0] thermalSet;
    logic [SET_W-1:0] motorConst;
  } jmb_motor_set_t;

  typedef struct packed {
    logic active;
    logic [FREQ_W-1:0] freq;
    logic stopReq;
    jmb_stop_t stopKind;
    logic refused;
  } jmb_jog_cmd_t;

  //////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam jmb_bank_t BANK_RESET = JMB_BANK1;
  localparam jmb_jog_cmd_t JOG_CMD_RESET = '0;
  localparam jmb_motor_set_t SET_RESET = '0;

endpackage

// *** jmb_sync.sv ***
// Two-stage synchroniser for a group of asynchronous input pins.
// Assumes the inputs are levels that stay stable for several clock periods.
`timescale 1ns/100ps
module jmb_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Pins and their synchronised copy.
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stable_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= '0;
      stable_ff <= '0;
    end else begin
      meta_ff <= pinIn;
      stable_ff <= meta_ff;
    end
  end

  assign syncOut = stable_ff;

endmodule

// *** jmb_term_model.sv ***
// Model of the controller that drives the intelligent input terminals.
// Assumes terminal 0 holds the jog code, 1 the second and 2 the third bank code.
`timescale 1ns/100ps
module jmb_term_model (
  // Clock.
  input wire logic clk,
  // Driven pins.
  output logic [7:0] termPin,
  output logic forwardRunPin,
  output logic reverseRunPin
);
  initial begin
    termPin = 8'h00;
    forwardRunPin = 1'b0;
    reverseRunPin = 1'b0;
  end

  task automatic setBank(input logic s2, input logic s3);
    @(negedge clk);
    termPin[2:1] = {s3, s2};
  endtask

  // Jog goes first; runFirst breaks that order on purpose.
  task automatic startJog(input logic useRev, input logic runFirst);
    @(negedge clk);
    if (runFirst) forwardRunPin = 1'b1;
    else termPin[0] = 1'b1;
    repeat (4) @(negedge clk);
    if (runFirst) termPin[0] = 1'b1;
    else if (useRev) reverseRunPin = 1'b1;
    else forwardRunPin = 1'b1;
  endtask

  task automatic endJog(input logic runFirst);
    @(negedge clk);
    if (runFirst) {forwardRunPin, reverseRunPin} = 2'h0;
    else termPin[0] = 1'b0;
    repeat (4) @(negedge clk);
    termPin[0] = 1'b0;
    {forwardRunPin, reverseRunPin} = 2'h0;
  endtask
endmodule
